// *** logic/asf_pkg.sv ***
// ****************************************************************
// Shared constants for the strobed FIFO controller
// ****************************************************************
package asf_pkg;
   // Data word width on the pins
   localparam int WORD_W = 9;
   // Timing figures in ns for the slowest speed grade
   localparam int CLK_NS = 8;
   localparam int T_PULSE_NS = 65;   // Strobe / clear / replay low width
   localparam int T_RECOV_NS = 15;   // Recovery high time after a strobe
   localparam int T_SETUP_NS = 65;   // Strobes high before clear falls
   localparam int T_ACCESS_NS = 65;  // Read access time
   localparam int T_FLAG_NS = 80;    // Flag settle after clear or replay
   // Cycle counts, least times rounded up
   localparam int PULSE_CYC = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int RECOV_CYC = (T_RECOV_NS + CLK_NS - 1) / CLK_NS;
   localparam int SETUP_CYC = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int ACCESS_CYC = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS;
   localparam int FLAG_CYC = (T_FLAG_NS + CLK_NS - 1) / CLK_NS;
   // Width of the phase timer
   localparam int TMR_W = 5;
   // Controller states
   typedef enum logic [2:0] {
      ASF_IDLE, ASF_SETUP, ASF_LOW, ASF_RECOV
   } asf_state_t;
   // Operation kinds
   typedef enum logic [1:0] {
      ASF_OP_CLEAR, ASF_OP_WRITE, ASF_OP_READ, ASF_OP_REPLAY
   } asf_op_t;
endpackage

// *** logic/asf_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Two-stage synchroniser for pin inputs
// ****************************************************************
module asf_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_q;  // First stage, read only by second stage
   // Both stages reset to the INIT value chosen by the parent
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_q <= INIT;
         sync_out <= INIT;
      end else begin
         meta_q <= pin_in;
         sync_out <= meta_q;
      end
   end
endmodule
`default_nettype wire

// *** logic/asf_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Issue master clear before any access
// - Strobes high before and after clear
// - Write data held around strobe rise
// - Strobes high during and after replay
// - Standalone: chain grounded, lead high
// - Depth ring: lead low first part
module asf_ctrl
   import asf_pkg::*;
#(
   parameter int WIDTH = asf_pkg::WORD_W,
   parameter bit DEPTH_MODE = 1'b0,   // Part sits in a depth ring
   parameter bit LEAD_PART = 1'b1     // First part of a depth ring
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   // User side
   input wire logic cmd_valid,
   input wire asf_pkg::asf_op_t cmd_op,
   input wire logic [WIDTH-1:0] cmd_wdata,
   output logic cmd_ready,
   output logic rsp_valid,
   output logic [WIDTH-1:0] rsp_rdata,
   output logic rsp_wdrop,
   output logic cleared,
   output logic empty_n,
   output logic half_n,
   output logic full_n,
   // Device pins
   output logic master_clear_n,
   output logic write_n,
   output logic read_n,
   output logic replay_n,
   output logic [WIDTH-1:0] write_word,
   input wire logic [WIDTH-1:0] read_word,
   input wire logic empty_flag_n,
   input wire logic half_flag_n,
   input wire logic full_flag_n,
   output logic lead_device_sel_n,
   output logic chain_in_tie_n
);
   import asf_pkg::*;

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [WIDTH+2:0] pins_s;   // Flags and data after two flops
   // Reset shows an empty buffer: empty low, half and full high
   asf_sync #(.W(WIDTH+3), .INIT({3'h3, {WIDTH{1'b0}}})) u_sync (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .pin_in({empty_flag_n, half_flag_n, full_flag_n, read_word}),
      .sync_out(pins_s)
   );
   wire logic ef_s = pins_s[WIDTH+2];
   wire logic hf_s = pins_s[WIDTH+1];
   wire logic ff_s = pins_s[WIDTH];
   wire logic [WIDTH-1:0] rd_s = pins_s[WIDTH-1:0];

   // ****************************************************************
   // State and timer
   // ****************************************************************
   asf_state_t state_q, state_d;
   asf_op_t op_q;                 // Operation in flight
   logic [TMR_W-1:0] tmr_q, tmr_d;
   logic cleared_q;               // A clear has completed
   logic skip_q;                  // Write/read refused by flag
   logic [WIDTH-1:0] wdata_q;
   logic [WIDTH-1:0] rdata_q;
   logic rsp_valid_q, wdrop_q;

   // Mode straps: lead select low only on ring leader
   assign lead_device_sel_n = DEPTH_MODE ? !LEAD_PART : 1'b1;
   assign chain_in_tie_n = 1'b0;  // Standalone grounds chain input

   // Gate requests: nothing but clear until first clear is done
   wire logic is_clear = (cmd_op == ASF_OP_CLEAR);
   wire logic replay_off = DEPTH_MODE && (cmd_op == ASF_OP_REPLAY);
   wire logic op_ok = is_clear || (cleared_q && !replay_off);
   assign cmd_ready = (state_q == ASF_IDLE) && op_ok;
   wire logic take = cmd_valid && cmd_ready;
   // Refusal on flags sampled at start
   wire logic refuse_w = (cmd_op == ASF_OP_WRITE) && !ff_s;
   wire logic refuse_r = (cmd_op == ASF_OP_READ) && !ef_s;
   wire logic tmr_done = (tmr_q == '0);

   // Phase lengths per operation
   wire logic [TMR_W-1:0] low_len = TMR_W'(op_q == ASF_OP_READ ? ACCESS_CYC : PULSE_CYC);
   wire logic [TMR_W-1:0] rec_len = TMR_W'((op_q == ASF_OP_WRITE || op_q == ASF_OP_READ)
                                           ? RECOV_CYC : FLAG_CYC);

   // Next-state logic
   always_comb begin
      state_d = state_q;
      tmr_d = tmr_done ? tmr_q : tmr_q - TMR_W'(1);
      case (state_q)
         ASF_IDLE: begin
            // Strobes are already high; setup counted before clear falls
            if (take) begin
               state_d = ASF_SETUP;
               tmr_d = TMR_W'(is_clear ? SETUP_CYC : 1);
            end
         end
         ASF_SETUP: begin
            if (tmr_done) begin
               state_d = skip_q ? ASF_IDLE : ASF_LOW;
               tmr_d = low_len;
            end
         end
         ASF_LOW: begin
            if (tmr_done) begin
               state_d = ASF_RECOV;
               tmr_d = rec_len;
            end
         end
         default: begin
            if (tmr_done) state_d = ASF_IDLE;
         end
      endcase
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   // Latch the operation on accept
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= ASF_IDLE;
         op_q <= ASF_OP_CLEAR;
         tmr_q <= '0;
         skip_q <= 1'b0;
         wdata_q <= '0;
      end else begin
         state_q <= state_d;
         tmr_q <= tmr_d;
         if (take) begin
            op_q <= cmd_op;
            skip_q <= refuse_w || refuse_r;
            wdata_q <= cmd_wdata;
         end
      end
   end

   // Completion pulses and read capture at end of access time
   wire logic finish = (state_q == ASF_RECOV) && tmr_done;
   wire logic cap_rd = (state_q == ASF_LOW) && tmr_done && (op_q == ASF_OP_READ);
   wire logic skip_end = (state_q == ASF_SETUP) && tmr_done && skip_q;
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_q <= '0;
         rsp_valid_q <= 1'b0;
         wdrop_q <= 1'b0;
         cleared_q <= 1'b0;
      end else begin
         if (cap_rd) rdata_q <= rd_s;  // Data valid after access time
         rsp_valid_q <= finish || skip_end;
         wdrop_q <= skip_end && (op_q == ASF_OP_WRITE);
         if (finish && op_q == ASF_OP_CLEAR) cleared_q <= 1'b1;
      end
   end

   // ****************************************************************
   // Pin drive
   // ****************************************************************
   wire logic low_ph = (state_q == ASF_LOW);
   assign master_clear_n = !(low_ph && op_q == ASF_OP_CLEAR);
   assign write_n = !(low_ph && op_q == ASF_OP_WRITE);
   assign read_n = !(low_ph && op_q == ASF_OP_READ);
   assign replay_n = !(low_ph && op_q == ASF_OP_REPLAY);
   assign write_word = wdata_q;  // Held through whole write and recovery
   assign rsp_valid = rsp_valid_q;
   assign rsp_rdata = rdata_q;
   assign rsp_wdrop = wdrop_q;
   assign cleared = cleared_q;
   assign empty_n = ef_s;
   assign half_n = DEPTH_MODE ? 1'b1 : hf_s;
   assign full_n = ff_s;

   // ****************************************************************
   // Checks
   // ****************************************************************
   a_early_access: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !cleared_q |-> (write_n && read_n && replay_n))
      else $error("access before master clear");
   a_strobes_clr: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !master_clear_n |-> (write_n && read_n))
      else $error("strobe low during clear");
   a_clr_recovery: assert property (@(posedge ref_clk) disable iff (!reset_n)
      $rose(master_clear_n) |-> (write_n && read_n)[*2])
      else $error("strobe too soon after clear");
   a_replay_quiet: assert property (@(posedge ref_clk) disable iff (!reset_n)
      $rose(replay_n) |-> (write_n && read_n)[*2])
      else $error("strobe during replay recovery");
   a_wr_data_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !write_n |=> $stable(write_word))
      else $error("write data moved");
   a_no_write_full: assert property (@(posedge ref_clk) disable iff (!reset_n)
      take && cmd_op == ASF_OP_WRITE && !ff_s |-> ##1 write_n [*3])
      else $error("write to full buffer");
   a_no_read_empty: assert property (@(posedge ref_clk) disable iff (!reset_n)
      take && cmd_op == ASF_OP_READ && !ef_s |-> ##1 read_n [*3])
      else $error("read from empty buffer");
   // Replay only outside a depth ring, after a clear, with both strobes high
   a_depth_no_replay: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !replay_n |-> (!DEPTH_MODE && cleared_q && write_n && read_n))
      else $error("replay in depth mode");
   a_low_width: assert property (@(posedge ref_clk) disable iff (!reset_n)
      $fell(write_n) |-> !write_n [*8])
      else $error("write pulse too short");
   c_clear: cover property (@(posedge ref_clk) $rose(cleared_q));
   c_write: cover property (@(posedge ref_clk) $fell(write_n));
   c_read: cover property (@(posedge ref_clk) $fell(read_n));
   c_replay: cover property (@(posedge ref_clk) $fell(replay_n));
endmodule
`default_nettype wire

// *** dv/asf_dev_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Behavioural strobed FIFO device, event driven from its pins
// ****************************************************************
module asf_dev_model #(
   parameter int DEPTH = 8
) (
   input wire logic master_clear_n,
   input wire logic write_n,
   input wire logic read_n,
   input wire logic replay_n,
   input wire logic [8:0] write_word,
   input wire logic chain_in_n,
   input wire logic lead_device_sel_n,
   output logic chain_out_n,
   output logic [8:0] read_word,
   output logic empty_flag_n,
   output logic half_flag_n,
   output logic full_flag_n,
   output logic [7:0] viol
);
   logic [8:0] mem [DEPTH];  // Storage
   logic [8:0] park = 9'h000;  // Last word driven, shown inverted once released
   int wp = 0;  // Write pointer
   int rp = 0;  // Read pointer
   int cnt = 0;  // Occupancy
   int wtot = 0;  // Words taken since the last clear, for replay
   bit wr_act = 1'b0;  // Write strobe low with room available
   bit rd_act = 1'b0;  // Read strobe low with data available
   bit ring = 1'b0;  // Depth ring mode, fixed at each clear
   initial viol = 8'h00;
   // Ring hand-off: low while the last location is being written or read
   wire logic last_wr = wr_act && (wp == DEPTH - 1);
   wire logic last_rd = rd_act && (rp == DEPTH - 1);
   assign chain_out_n = !(ring && (last_wr || last_rd));
   // Pending strobes move flags early: falling write edges lower full/half
   assign empty_flag_n = (cnt - rd_act) != 0;
   assign half_flag_n = (cnt + wr_act) <= DEPTH / 2;
   assign full_flag_n = (cnt + wr_act) < DEPTH;
   // Released bus never holds the last value, so a stale sample is caught
   assign read_word = (rd_act && !read_n) ? mem[rp] : ~park;
   // Clear empties the store and rewinds both pointers
   always @(negedge master_clear_n) begin
      wp = 0;
      rp = 0;
      cnt = 0;
      wtot = 0;
      // Mode straps: a grounded chain input means standalone, lead must be high
      ring = (chain_in_n !== 1'b0);
      if (!ring && lead_device_sel_n !== 1'b1) viol++;
   end
   // Strobes must stand high around the clear edge and during replay
   always @(posedge master_clear_n) begin
      if (!read_n || !write_n) viol++;
   end
   always @(negedge write_n) wr_act = cnt < DEPTH;
   always @(posedge write_n) begin
      if (wr_act) begin
         mem[wp] = write_word;
         wp = (wp + 1) % DEPTH;
         cnt++;
         wtot++;
         wr_act = 1'b0;
      end
   end
   always @(negedge read_n) rd_act = cnt > 0;
   always @(posedge read_n) begin
      if (rd_act) begin
         park = mem[rp];
         rp = (rp + 1) % DEPTH;
         cnt--;
         rd_act = 1'b0;
      end
   end
   // Replay rewinds reads; flags follow the words written since the last clear
   always @(negedge replay_n) begin
      if (!read_n || !write_n) viol++;
      rp = 0;
      cnt = wtot;
   end
endmodule
`default_nettype wire

// *** dv/async_strobed_fifo_core_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Self-checking bench: controller against the device model
// ****************************************************************
module async_strobed_fifo_core_tb;
   import asf_pkg::*;
   localparam int D = 8;  // Small depth keeps the run short
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic cmd_valid = 1'b0;
   asf_op_t cmd_op = ASF_OP_CLEAR;
   logic [8:0] cmd_wdata = 9'h000;
   logic cmd_ready, rsp_valid, rsp_wdrop, cleared, empty_n, half_n, full_n;
   logic [8:0] rsp_rdata, write_word, read_word;
   logic master_clear_n, write_n, read_n, replay_n, empty_flag_n, half_flag_n, full_flag_n;
   logic [7:0] viol;
   logic lead_sel_n, chain_tie_n, chain_out_n;
   int n_fail = 0;
   int cmp_count = 0;
   logic [8:0] q[$];  // Reference contents
   logic [8:0] hist[$];  // Words since clear, restored by replay
   asf_ctrl dut (.ref_clk, .reset_n, .cmd_valid, .cmd_op, .cmd_wdata, .cmd_ready, .rsp_valid,
      .rsp_rdata, .rsp_wdrop, .cleared, .empty_n, .half_n, .full_n, .master_clear_n, .write_n,
      .read_n, .replay_n, .write_word, .read_word, .empty_flag_n, .half_flag_n, .full_flag_n,
      .lead_device_sel_n(lead_sel_n), .chain_in_tie_n(chain_tie_n));
   asf_dev_model #(.DEPTH(D)) dev (.master_clear_n, .write_n, .read_n, .replay_n, .write_word,
      .chain_in_n(chain_tie_n), .lead_device_sel_n(lead_sel_n), .chain_out_n,
      .read_word, .empty_flag_n, .half_flag_n, .full_flag_n, .viol);
   initial forever #4 ref_clk = ~ref_clk;
   task automatic check(input string nm, input logic [8:0] seen, input logic [8:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // One operation: hold the request to its accept edge, then await the answer
   task automatic run(input asf_op_t o);
      int n;
      logic [8:0] d;
      d = 9'($urandom);
      n = 0;
      @(negedge ref_clk);
      cmd_op = o;
      cmd_wdata = d;
      cmd_valid = 1'b1;
      // Let the ready decode follow the new operation before looking at it
      #1;
      while (cmd_ready !== 1'b1 && n < 50) begin
         @(negedge ref_clk);
         n++;
      end
      @(negedge ref_clk);
      cmd_valid = 1'b0;
      n = 0;
      do begin
         @(posedge ref_clk);
         #1;
         n++;
      end while (rsp_valid !== 1'b1 && n < 100);
      check("rsp_valid", rsp_valid, 1'b1);
      case (o)
         ASF_OP_CLEAR: begin
            q = {};
            hist = {};
            check("cleared", cleared, 1'b1);
         end
         ASF_OP_WRITE: begin
            check("rsp_wdrop", rsp_wdrop, q.size() == D);
            if (q.size() < D) begin
               q.push_back(d);
               hist.push_back(d);
            end
         end
         ASF_OP_READ: begin
            if (q.size() > 0) begin
               check("rsp_rdata", rsp_rdata, q.pop_front());
            end
         end
         default: q = hist;  // Replay restores everything written since clear
      endcase
      check("empty_n", empty_n, q.size() != 0);
      check("half_n", half_n, q.size() <= D / 2);
      check("full_n", full_n, q.size() < D);
      check("chain_out_n", chain_out_n, 1'b1);
   endtask
   initial begin
      void'($urandom(28748));
      repeat (20) @(posedge ref_clk);
      @(negedge ref_clk);
      reset_n = 1'b1;
      @(negedge ref_clk);
      cmd_op = ASF_OP_WRITE;
      #1;
      check("cmd_ready", cmd_ready, 1'b0);
      check("lead_sel_n", lead_sel_n, 1'b1);
      check("chain_tie_n", chain_tie_n, 1'b0);
      run(ASF_OP_CLEAR);
      run(ASF_OP_READ);
      repeat (D + 1) run(ASF_OP_WRITE);
      repeat (D / 2 + 1) run(ASF_OP_READ);
      run(ASF_OP_REPLAY);
      repeat (D + 1) run(ASF_OP_READ);
      repeat (3) run(ASF_OP_WRITE);
      repeat (3) run(ASF_OP_READ);
      run(ASF_OP_CLEAR);
      run(ASF_OP_WRITE);
      run(ASF_OP_READ);
      check("viol", viol, 8'h00);
      print_verdict();
   end
   // Watchdog: far beyond the few hundred cycles the sequence needs
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_fail++;
      print_verdict();
   end
endmodule
`default_nettype wire
